// ### pcdec_decoder.sv
`timescale 1ns/10ps
`include "pcdec_map.svh"

module pcdec_decoder (
  // Clock and reset
  input  wire logic                    CLOCK,
  input  wire logic                    RST_B,
  // Byte stream from the prefetch queue
  input  wire pcdec_pkg::pcdec_byte_t  QUEUE_BYTE,
  // Processor mode, high in protected mode
  input  wire logic                    PROT_MODE,
  // Decoded instruction
  output pcdec_pkg::pcdec_result_t     DECODED,
  // Hand-off to the numeric coprocessor
  output pcdec_pkg::pcdec_escape_t     COPROC_ESCAPE,
  // Invalid-opcode exception request
  output logic                         INVALID_OPCODE,
  // Instruction outside this group
  output pcdec_pkg::pcdec_foreign_t    FOREIGN
);
  import pcdec_pkg::*;

  pcdec_state_t  state;
  pcdec_kind_t   kind;
  logic [7:0]    first_byte;
  logic          seg_pending;
  logic [1:0]    seg_reg;

  pcdec_state_t  next_state;
  pcdec_kind_t   next_kind;
  pcdec_op_t     next_op;
  logic          next_done;
  logic          next_invalid;
  logic          next_foreign;
  logic          next_escape;
  logic          next_seg_prefix;
  logic [2:0]    modrm_reg;
  logic [9:0]    next_clocks;

  // Least and most clock count for each decoded operation
  function automatic logic [9:0] clocks_of(input pcdec_op_t op);
    case (op)
      PCDEC_OP_COPROC_ESCAPE: clocks_of = {`PCDEC_CLK_ESC_MIN, `PCDEC_CLK_ESC_MAX};
      PCDEC_OP_SEG_OVERRIDE:  clocks_of = {`PCDEC_CLK_SEG, `PCDEC_CLK_SEG};
      PCDEC_OP_LOAD_GDT:      clocks_of = {`PCDEC_CLK_GDT, `PCDEC_CLK_GDT};
      PCDEC_OP_STORE_GDT:     clocks_of = {`PCDEC_CLK_GDT, `PCDEC_CLK_GDT};
      PCDEC_OP_LOAD_IDT:      clocks_of = {`PCDEC_CLK_IDT, `PCDEC_CLK_IDT};
      PCDEC_OP_STORE_IDT:     clocks_of = {`PCDEC_CLK_IDT, `PCDEC_CLK_IDT};
      PCDEC_OP_LOAD_LDT:      clocks_of = {`PCDEC_CLK_LOAD_SEL_MIN, `PCDEC_CLK_LOAD_SEL_MAX};
      PCDEC_OP_STORE_LDT:     clocks_of = {`PCDEC_CLK_STORE_MIN, `PCDEC_CLK_STORE_MAX};
      PCDEC_OP_LOAD_TASK:     clocks_of = {`PCDEC_CLK_LOAD_SEL_MIN, `PCDEC_CLK_LOAD_SEL_MAX};
      PCDEC_OP_STORE_TASK:    clocks_of = {`PCDEC_CLK_STORE_MIN, `PCDEC_CLK_STORE_MAX};
      PCDEC_OP_LOAD_MSW:      clocks_of = {`PCDEC_CLK_LOAD_MACHINE_STATUS_WORD_MIN, `PCDEC_CLK_LOAD_MACHINE_STATUS_WORD_MAX};
      PCDEC_OP_STORE_MSW:     clocks_of = {`PCDEC_CLK_STORE_MIN, `PCDEC_CLK_STORE_MAX};
      PCDEC_OP_LOAD_ACCESS:   clocks_of = {`PCDEC_CLK_CHECK_MIN, `PCDEC_CLK_CHECK_MAX};
      PCDEC_OP_LOAD_LIMIT:    clocks_of = {`PCDEC_CLK_CHECK_MIN, `PCDEC_CLK_CHECK_MAX};
      PCDEC_OP_ADJUST_PRIV:   clocks_of = {`PCDEC_CLK_ADJUST_REQUESTED_PRIVILEGE_MIN, `PCDEC_CLK_ADJUST_REQUESTED_PRIVILEGE_MAX};
      PCDEC_OP_VERIFY_READ:   clocks_of = {`PCDEC_CLK_CHECK_MIN, `PCDEC_CLK_CHECK_MAX};
      PCDEC_OP_VERIFY_WRITE:  clocks_of = {`PCDEC_CLK_CHECK_MIN, `PCDEC_CLK_CHECK_MAX};
      default:                clocks_of = 10'h000;
    endcase
  endfunction

  // True for operations that exist only in protected mode
  function automatic logic prot_only(input pcdec_op_t op);
    case (op)
      PCDEC_OP_LOAD_LDT,
      PCDEC_OP_STORE_LDT,
      PCDEC_OP_LOAD_TASK,
      PCDEC_OP_STORE_TASK,
      PCDEC_OP_LOAD_ACCESS,
      PCDEC_OP_LOAD_LIMIT:    prot_only = 1'b1;
      default:                prot_only = 1'b0;
    endcase
  endfunction

  // Group 0 reg field decode; NONE marks an unlisted value
  function automatic pcdec_op_t group0_op(input logic [2:0] r);
    case (r)
      `PCDEC_G0_STORE_LDT:    group0_op = PCDEC_OP_STORE_LDT;
      `PCDEC_G0_STORE_TASK:   group0_op = PCDEC_OP_STORE_TASK;
      `PCDEC_G0_LOAD_LDT:     group0_op = PCDEC_OP_LOAD_LDT;
      `PCDEC_G0_LOAD_TASK:    group0_op = PCDEC_OP_LOAD_TASK;
      `PCDEC_G0_VERIFY_READ:  group0_op = PCDEC_OP_VERIFY_READ;
      `PCDEC_G0_VERIFY_WRITE: group0_op = PCDEC_OP_VERIFY_WRITE;
      default:                group0_op = PCDEC_OP_NONE;
    endcase
  endfunction

  // Group 1 reg field decode; NONE marks an unlisted value
  function automatic pcdec_op_t group1_op(input logic [2:0] r);
    case (r)
      `PCDEC_G1_STORE_GDT:    group1_op = PCDEC_OP_STORE_GDT;
      `PCDEC_G1_STORE_IDT:    group1_op = PCDEC_OP_STORE_IDT;
      `PCDEC_G1_LOAD_GDT:     group1_op = PCDEC_OP_LOAD_GDT;
      `PCDEC_G1_LOAD_IDT:     group1_op = PCDEC_OP_LOAD_IDT;
      `PCDEC_G1_STORE_MSW:    group1_op = PCDEC_OP_STORE_MSW;
      `PCDEC_G1_LOAD_MSW:     group1_op = PCDEC_OP_LOAD_MSW;
      default:                group1_op = PCDEC_OP_NONE;
    endcase
  endfunction

  assign modrm_reg = QUEUE_BYTE.data[`PCDEC_MODRM_REG_HI:`PCDEC_MODRM_REG_LO];

  // A function result cannot be part-selected, so the packed counts get a net
  assign next_clocks = clocks_of(next_op);

  // Byte-by-byte decode; one byte is taken each cycle it is valid
  always_comb begin
    next_state      = state;
    next_kind       = kind;
    next_op         = PCDEC_OP_NONE;
    next_done       = 1'b0;
    next_invalid    = 1'b0;
    next_foreign    = 1'b0;
    next_escape     = 1'b0;
    next_seg_prefix = 1'b0;
    if (QUEUE_BYTE.valid) begin
      case (state)
        PCDEC_ST_FIRST: begin
          if ((QUEUE_BYTE.data & `PCDEC_ESC_MASK) == `PCDEC_ESC_MATCH) begin
            next_kind  = PCDEC_K_ESCAPE;
            next_state = PCDEC_ST_MODRM;
          end else if ((QUEUE_BYTE.data & `PCDEC_SEG_MASK) == `PCDEC_SEG_MATCH) begin
            next_seg_prefix = 1'b1;
            next_op         = PCDEC_OP_SEG_OVERRIDE;
            next_done       = 1'b1;
          end else if (QUEUE_BYTE.data == `PCDEC_TWO_BYTE_ESCAPE) begin
            next_state = PCDEC_ST_SECOND;
          end else if (QUEUE_BYTE.data == `PCDEC_ADJ_PRIV_OPCODE) begin
            next_kind  = PCDEC_K_ADJUST;
            next_state = PCDEC_ST_MODRM;
          end else begin
            next_foreign = 1'b1;
          end
        end
        PCDEC_ST_SECOND: begin
          next_state = PCDEC_ST_MODRM;
          case (QUEUE_BYTE.data)
            `PCDEC_SEC_GROUP0:        next_kind = PCDEC_K_GROUP0;
            `PCDEC_SEC_GROUP1:        next_kind = PCDEC_K_GROUP1;
            `PCDEC_SEC_ACCESS_RIGHTS: next_kind = PCDEC_K_ACCESS;
            `PCDEC_SEC_SEG_LIMIT:     next_kind = PCDEC_K_LIMIT;
            default: begin
              next_foreign = 1'b1;
              next_state   = PCDEC_ST_FIRST;
            end
          endcase
        end
        PCDEC_ST_MODRM: begin
          next_state = PCDEC_ST_FIRST;
          next_done  = 1'b1;
          case (kind)
            PCDEC_K_GROUP0: next_op = group0_op(modrm_reg);
            PCDEC_K_GROUP1: next_op = group1_op(modrm_reg);
            PCDEC_K_ACCESS: next_op = PCDEC_OP_LOAD_ACCESS;
            PCDEC_K_LIMIT:  next_op = PCDEC_OP_LOAD_LIMIT;
            PCDEC_K_ADJUST: next_op = PCDEC_OP_ADJUST_PRIV;
            PCDEC_K_ESCAPE: begin
              next_op     = PCDEC_OP_COPROC_ESCAPE;
              next_escape = 1'b1;
            end
            default:        next_op = PCDEC_OP_NONE;
          endcase
          if (next_op == PCDEC_OP_NONE) begin
            next_done    = 1'b0;
            next_invalid = 1'b1;
          end else if (prot_only(next_op) && !PROT_MODE) begin
            // Real mode has no count for these, so they trap instead
            next_done    = 1'b0;
            next_invalid = 1'b1;
          end
        end
        default: begin
          next_state = PCDEC_ST_FIRST;
        end
      endcase
    end
  end

  // Sequencer state
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state      <= PCDEC_ST_FIRST;
      kind       <= PCDEC_K_GROUP0;
      first_byte <= 8'h00;
    end else begin
      state <= next_state;
      kind  <= next_kind;
      if (QUEUE_BYTE.valid && state == PCDEC_ST_FIRST) begin
        first_byte <= QUEUE_BYTE.data;
      end
    end
  end

  // Pending segment override, held until the instruction it prefixes ends
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      seg_pending <= 1'b0;
      seg_reg     <= 2'h0;
    end else if (next_seg_prefix) begin
      seg_pending <= 1'b1;
      seg_reg     <= QUEUE_BYTE.data[`PCDEC_SEG_REG_HI:`PCDEC_SEG_REG_LO];
    end else if (next_done || next_invalid || next_foreign) begin
      seg_pending <= 1'b0;
    end
  end

  // Decoded result, one-cycle valid
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      DECODED <= '0;
    end else begin
      DECODED.valid     <= next_done;
      DECODED.op        <= next_op;
      DECODED.modrm_reg <= next_seg_prefix ? 3'h0 : modrm_reg;
      DECODED.modrm     <= next_seg_prefix ? 8'h00 : QUEUE_BYTE.data;
      DECODED.clk_min   <= next_clocks[9:5];
      DECODED.clk_max   <= next_clocks[4:0];
      // A prefix reports its own register; the next instruction inherits it
      DECODED.seg_valid <= next_seg_prefix | (next_done & seg_pending);
      DECODED.seg_reg   <= next_seg_prefix ?
                           QUEUE_BYTE.data[`PCDEC_SEG_REG_HI:`PCDEC_SEG_REG_LO] : seg_reg;
    end
  end

  // Coprocessor hand-off
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      COPROC_ESCAPE <= '0;
    end else begin
      COPROC_ESCAPE.valid                   <= next_escape;
      COPROC_ESCAPE.escape_high_opcode_bits <= first_byte[2:0];
      COPROC_ESCAPE.escape_low_opcode_bits  <= modrm_reg;
      COPROC_ESCAPE.modrm                   <= QUEUE_BYTE.data;
    end
  end

  // Exception request
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      INVALID_OPCODE <= 1'b0;
    end else begin
      INVALID_OPCODE <= next_invalid;
    end
  end

  // Bytes that belong to another decoder are passed on, not dropped
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      FOREIGN <= '0;
    end else begin
      FOREIGN.valid    <= next_foreign;
      FOREIGN.two_byte <= (state == PCDEC_ST_SECOND);
      FOREIGN.first    <= (state == PCDEC_ST_SECOND) ? first_byte : QUEUE_BYTE.data;
      FOREIGN.second   <= (state == PCDEC_ST_SECOND) ? QUEUE_BYTE.data : 8'h00;
    end
  end

endmodule // pcdec_decoder

// ### pcdec_map.svh
`ifndef PCDEC_MAP_SVH
`define PCDEC_MAP_SVH

// Opcode bytes
`define PCDEC_TWO_BYTE_ESCAPE   8'h0f
`define PCDEC_SEC_GROUP0        8'h00
`define PCDEC_SEC_GROUP1        8'h01
`define PCDEC_SEC_ACCESS_RIGHTS 8'h02
`define PCDEC_SEC_SEG_LIMIT     8'h03
`define PCDEC_ADJ_PRIV_OPCODE   8'h63

// Pattern fields: coprocessor escape 11011TTT, segment prefix 001 rr 110
`define PCDEC_ESC_MASK          8'hf8
`define PCDEC_ESC_MATCH         8'hd8
`define PCDEC_SEG_MASK          8'he7
`define PCDEC_SEG_MATCH         8'h26

// ModRM and segment prefix field positions
`define PCDEC_MODRM_REG_HI      5
`define PCDEC_MODRM_REG_LO      3
`define PCDEC_SEG_REG_HI        4
`define PCDEC_SEG_REG_LO        3

// Group 0 reg field codes
`define PCDEC_G0_STORE_LDT      3'h0
`define PCDEC_G0_STORE_TASK     3'h1
`define PCDEC_G0_LOAD_LDT       3'h2
`define PCDEC_G0_LOAD_TASK      3'h3
`define PCDEC_G0_VERIFY_READ    3'h4
`define PCDEC_G0_VERIFY_WRITE   3'h5

// Group 1 reg field codes
`define PCDEC_G1_STORE_GDT      3'h0
`define PCDEC_G1_STORE_IDT      3'h1
`define PCDEC_G1_LOAD_GDT       3'h2
`define PCDEC_G1_LOAD_IDT       3'h3
`define PCDEC_G1_STORE_MSW      3'h4
`define PCDEC_G1_LOAD_MSW       3'h6

// Execution clock counts, least and most
`define PCDEC_CLK_ESC_MIN       5'h09
`define PCDEC_CLK_ESC_MAX       5'h14
`define PCDEC_CLK_SEG           5'h00
`define PCDEC_CLK_GDT           5'h0b
`define PCDEC_CLK_IDT           5'h0c
`define PCDEC_CLK_LOAD_SEL_MIN  5'h11
`define PCDEC_CLK_LOAD_SEL_MAX  5'h13
`define PCDEC_CLK_STORE_MIN     5'h02
`define PCDEC_CLK_STORE_MAX     5'h03
`define PCDEC_CLK_LOAD_MACHINE_STATUS_WORD_MIN      5'h03
`define PCDEC_CLK_LOAD_MACHINE_STATUS_WORD_MAX      5'h06
`define PCDEC_CLK_CHECK_MIN     5'h0e
`define PCDEC_CLK_CHECK_MAX     5'h10
`define PCDEC_CLK_ADJUST_REQUESTED_PRIVILEGE_MIN      5'h0a
`define PCDEC_CLK_ADJUST_REQUESTED_PRIVILEGE_MAX      5'h0b

`endif

// ### pcdec_pkg.sv
package pcdec_pkg;

  typedef enum logic [4:0] {
    PCDEC_OP_NONE           = 5'h00,
    PCDEC_OP_COPROC_ESCAPE  = 5'h01,
    PCDEC_OP_SEG_OVERRIDE   = 5'h02,
    PCDEC_OP_LOAD_GDT       = 5'h03,
    PCDEC_OP_STORE_GDT      = 5'h04,
    PCDEC_OP_LOAD_IDT       = 5'h05,
    PCDEC_OP_STORE_IDT      = 5'h06,
    PCDEC_OP_LOAD_LDT       = 5'h07,
    PCDEC_OP_STORE_LDT      = 5'h08,
    PCDEC_OP_LOAD_TASK      = 5'h09,
    PCDEC_OP_STORE_TASK     = 5'h0a,
    PCDEC_OP_LOAD_MSW       = 5'h0b,
    PCDEC_OP_STORE_MSW      = 5'h0c,
    PCDEC_OP_LOAD_ACCESS    = 5'h0d,
    PCDEC_OP_LOAD_LIMIT     = 5'h0e,
    PCDEC_OP_ADJUST_PRIV    = 5'h0f,
    PCDEC_OP_VERIFY_READ    = 5'h10,
    PCDEC_OP_VERIFY_WRITE   = 5'h11
  } pcdec_op_t;

  typedef enum logic [1:0] {
    PCDEC_ST_FIRST  = 2'b00,
    PCDEC_ST_SECOND = 2'b01,
    PCDEC_ST_MODRM  = 2'b10
  } pcdec_state_t;

  typedef enum logic [2:0] {
    PCDEC_K_GROUP0  = 3'b000,
    PCDEC_K_GROUP1  = 3'b001,
    PCDEC_K_ACCESS  = 3'b010,
    PCDEC_K_LIMIT   = 3'b011,
    PCDEC_K_ADJUST  = 3'b100,
    PCDEC_K_ESCAPE  = 3'b101
  } pcdec_kind_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } pcdec_byte_t;

  typedef struct packed {
    logic       valid;
    pcdec_op_t  op;
    logic [2:0] modrm_reg;
    logic [7:0] modrm;
    logic [4:0] clk_min;
    logic [4:0] clk_max;
    logic       seg_valid;
    logic [1:0] seg_reg;
  } pcdec_result_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] escape_high_opcode_bits;
    logic [2:0] escape_low_opcode_bits;
    logic [7:0] modrm;
  } pcdec_escape_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] first;
    logic [7:0] second;
    logic       two_byte;
  } pcdec_foreign_t;

endpackage

// ### pcdec_feeder_model.sv
`timescale 1ns/10ps
module pcdec_feeder (
  // Clock
  input  wire logic              clock,
  // Random idle cycles between bytes
  input  wire logic              gap_en,
  // Byte stream to the decoder
  output pcdec_pkg::pcdec_byte_t q_byte
);
  import pcdec_pkg::*;
  logic [7:0] fifo[$];
  initial q_byte = '0;
  // Idle cycles show a changing byte, so a decoder that ignores valid is caught
  always @(negedge clock) begin
    if (fifo.size() > 0 && !(gap_en && $urandom_range(2) == 0)) begin
      q_byte.valid <= 1'b1;
      q_byte.data  <= fifo.pop_front();
    end else begin
      q_byte.valid <= 1'b0;
      q_byte.data  <= ~q_byte.data;
    end
  end
endmodule // pcdec_feeder

// ### pcdec_checker_properties.sv
`timescale 1ns/10ps
module pcdec_checker (
  // Clock and reset
  input wire logic                     CLOCK,
  input wire logic                     RST_B,
  // Watched ports
  input wire pcdec_pkg::pcdec_byte_t   QUEUE_BYTE,
  input wire logic                     PROT_MODE,
  input wire pcdec_pkg::pcdec_result_t DECODED,
  input wire pcdec_pkg::pcdec_escape_t COPROC_ESCAPE,
  input wire logic                     INVALID_OPCODE,
  input wire pcdec_pkg::pcdec_foreign_t FOREIGN
);
  import pcdec_pkg::*;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  logic       dv;
  pcdec_op_t  op;
  logic [9:0] clk;
  logic [2:0] rg;
  assign dv  = DECODED.valid;
  assign op  = DECODED.op;
  assign clk = {DECODED.clk_min, DECODED.clk_max};
  assign rg  = DECODED.modrm_reg;
  property p_escape;
    COPROC_ESCAPE.valid |-> dv && op == PCDEC_OP_COPROC_ESCAPE && clk == {5'h09, 5'h14}
      && COPROC_ESCAPE.escape_low_opcode_bits == $past(QUEUE_BYTE.data[5:3]);
  endproperty
  property p_taken;
    dv || INVALID_OPCODE || FOREIGN.valid |-> $past(QUEUE_BYTE.valid);
  endproperty
  property p_modrm;
    dv && op != PCDEC_OP_SEG_OVERRIDE |-> DECODED.modrm == $past(QUEUE_BYTE.data)
      && rg == DECODED.modrm[5:3];
  endproperty
  property p_seg;
    dv && op == PCDEC_OP_SEG_OVERRIDE |-> clk == 10'h000 && DECODED.seg_valid
      && ($past(QUEUE_BYTE.data) & 8'he7) == 8'h26 && DECODED.seg_reg == $past(QUEUE_BYTE.data[4:3]);
  endproperty
  property p_gdt;
    dv && op inside {PCDEC_OP_LOAD_GDT, PCDEC_OP_STORE_GDT} |-> clk == {5'h0b, 5'h0b}
      && rg == ((op == PCDEC_OP_LOAD_GDT) ? 3'h2 : 3'h0);
  endproperty
  property p_idt;
    dv && op inside {PCDEC_OP_LOAD_IDT, PCDEC_OP_STORE_IDT} |-> clk == {5'h0c, 5'h0c}
      && rg == ((op == PCDEC_OP_LOAD_IDT) ? 3'h3 : 3'h1);
  endproperty
  property p_sel_load;
    dv && op inside {PCDEC_OP_LOAD_LDT, PCDEC_OP_LOAD_TASK} |-> $past(PROT_MODE) && clk == {5'h11, 5'h13};
  endproperty
  property p_sel_store;
    dv && op inside {PCDEC_OP_STORE_LDT, PCDEC_OP_STORE_TASK} |-> $past(PROT_MODE) && clk == {5'h02, 5'h03};
  endproperty
  property p_msw;
    dv && op inside {PCDEC_OP_LOAD_MSW, PCDEC_OP_STORE_MSW} |-> (op == PCDEC_OP_LOAD_MSW) ?
      (clk == {5'h03, 5'h06} && rg == 3'h6) : (clk == {5'h02, 5'h03} && rg == 3'h4);
  endproperty
  property p_check;
    dv && op inside {PCDEC_OP_LOAD_ACCESS, PCDEC_OP_LOAD_LIMIT, PCDEC_OP_VERIFY_READ, PCDEC_OP_VERIFY_WRITE}
      |-> clk == {5'h0e, 5'h10} && (op inside {PCDEC_OP_VERIFY_READ, PCDEC_OP_VERIFY_WRITE} || $past(PROT_MODE));
  endproperty
  property p_adjust_requested_privilege;
    dv && op == PCDEC_OP_ADJUST_PRIV |-> clk == {5'h0a, 5'h0b};
  endproperty
  property p_invalid;
    INVALID_OPCODE |-> !dv && !FOREIGN.valid && !COPROC_ESCAPE.valid;
  endproperty
  a_escape: assert property (p_escape) else $error("escape hand-off wrong");
  a_taken: assert property (p_taken) else $error("result without a byte");
  a_modrm: assert property (p_modrm) else $error("operand byte wrong");
  a_seg: assert property (p_seg) else $error("prefix result wrong");
  a_gdt: assert property (p_gdt) else $error("global table decode wrong");
  a_idt: assert property (p_idt) else $error("interrupt table decode wrong");
  a_sel_load: assert property (p_sel_load) else $error("selector load wrong");
  a_sel_store: assert property (p_sel_store) else $error("selector store wrong");
  a_msw: assert property (p_msw) else $error("status word decode wrong");
  a_check: assert property (p_check) else $error("access check decode wrong");
  a_adjust_requested_privilege: assert property (p_adjust_requested_privilege) else $error("privilege adjust count wrong");
  a_invalid: assert property (p_invalid) else $error("invalid beside a result");
  c_escape: cover property (COPROC_ESCAPE.valid);
  c_invalid: cover property (INVALID_OPCODE);
  c_seg: cover property (dv && op == PCDEC_OP_SEG_OVERRIDE);
  c_foreign: cover property (FOREIGN.valid && FOREIGN.two_byte);
endmodule // pcdec_checker

bind pcdec_decoder pcdec_checker pcdec_checker_i (
  .CLOCK(CLOCK), .RST_B(RST_B), .QUEUE_BYTE(QUEUE_BYTE), .PROT_MODE(PROT_MODE),
  .DECODED(DECODED), .COPROC_ESCAPE(COPROC_ESCAPE), .INVALID_OPCODE(INVALID_OPCODE),
  .FOREIGN(FOREIGN));

// ### tb.sv
`timescale 1ns/10ps
module tb;
  import pcdec_pkg::*;
  typedef struct packed {
    logic [1:0] kind;
    pcdec_op_t  op;
    logic [4:0] cmin;
    logic [4:0] cmax;
  } pcdec_tb_exp_t;
  logic           CLOCK = 1'b0;
  logic           RST_B = 1'b0;
  logic           PROT_MODE = 1'b0;
  logic           gap_en = 1'b0;
  pcdec_byte_t    QUEUE_BYTE;
  pcdec_result_t  DECODED;
  pcdec_escape_t  COPROC_ESCAPE;
  logic           INVALID_OPCODE;
  pcdec_foreign_t FOREIGN;
  int             err_total = 0;
  int             compares = 0;
  logic           seg_pend = 1'b0;
  logic [1:0]     seg_r = 2'h0;
  logic [7:0]     rm;
  logic [7:0]     rb;
  int             rk;

  always #4 CLOCK = ~CLOCK;

  pcdec_feeder pcdec_feeder_i (.clock(CLOCK), .gap_en(gap_en), .q_byte(QUEUE_BYTE));
  pcdec_decoder pcdec_decoder_i (.CLOCK(CLOCK), .RST_B(RST_B), .QUEUE_BYTE(QUEUE_BYTE),
    .PROT_MODE(PROT_MODE), .DECODED(DECODED), .COPROC_ESCAPE(COPROC_ESCAPE),
    .INVALID_OPCODE(INVALID_OPCODE), .FOREIGN(FOREIGN));

  task automatic final_report;
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask

  function automatic pcdec_tb_exp_t mk(pcdec_op_t op, logic [4:0] mn, logic [4:0] mx);
    return '{2'h0, op, mn, mx};
  endfunction

  // Kind 0 decoded, 1 invalid, 2 foreign
  function automatic pcdec_tb_exp_t expect_of(logic [7:0] b0, logic [7:0] b1, logic [7:0] m,
                                              logic pm);
    pcdec_tb_exp_t e;
    e = '{2'h1, PCDEC_OP_NONE, 5'h00, 5'h00};
    if ((b0 & 8'hf8) == 8'hd8) e = mk(PCDEC_OP_COPROC_ESCAPE, 5'h09, 5'h14);
    else if ((b0 & 8'he7) == 8'h26) e = mk(PCDEC_OP_SEG_OVERRIDE, 5'h00, 5'h00);
    else if (b0 == 8'h63) e = mk(PCDEC_OP_ADJUST_PRIV, 5'h0a, 5'h0b);
    else if (b0 != 8'h0f || b1 > 8'h03) e.kind = 2'h2;
    else if (b1 == 8'h02) e = mk(PCDEC_OP_LOAD_ACCESS, 5'h0e, 5'h10);
    else if (b1 == 8'h03) e = mk(PCDEC_OP_LOAD_LIMIT, 5'h0e, 5'h10);
    else if (b1 == 8'h00) case (m[5:3])
      3'h0: e = mk(PCDEC_OP_STORE_LDT, 5'h02, 5'h03);
      3'h1: e = mk(PCDEC_OP_STORE_TASK, 5'h02, 5'h03);
      3'h2: e = mk(PCDEC_OP_LOAD_LDT, 5'h11, 5'h13);
      3'h3: e = mk(PCDEC_OP_LOAD_TASK, 5'h11, 5'h13);
      3'h4: e = mk(PCDEC_OP_VERIFY_READ, 5'h0e, 5'h10);
      3'h5: e = mk(PCDEC_OP_VERIFY_WRITE, 5'h0e, 5'h10);
      default: ;
    endcase
    else case (m[5:3])
      3'h0: e = mk(PCDEC_OP_STORE_GDT, 5'h0b, 5'h0b);
      3'h1: e = mk(PCDEC_OP_STORE_IDT, 5'h0c, 5'h0c);
      3'h2: e = mk(PCDEC_OP_LOAD_GDT, 5'h0b, 5'h0b);
      3'h3: e = mk(PCDEC_OP_LOAD_IDT, 5'h0c, 5'h0c);
      3'h4: e = mk(PCDEC_OP_STORE_MSW, 5'h02, 5'h03);
      3'h6: e = mk(PCDEC_OP_LOAD_MSW, 5'h03, 5'h06);
      default: ;
    endcase
    if (!pm && e.op inside {PCDEC_OP_STORE_LDT, PCDEC_OP_STORE_TASK, PCDEC_OP_LOAD_LDT,
        PCDEC_OP_LOAD_TASK, PCDEC_OP_LOAD_ACCESS, PCDEC_OP_LOAD_LIMIT}) begin
      e = '{2'h1, PCDEC_OP_NONE, 5'h00, 5'h00};
    end
    return e;
  endfunction

  // Mode is held for the whole instruction, since it is sampled with the last byte
  task automatic run(input logic [7:0] b0, b1, b2, input int n, input logic pm);
    pcdec_tb_exp_t e;
    logic [7:0]    m;
    int            w;
    m = (n == 3) ? b2 : b1;
    e = expect_of(b0, b1, m, pm);
    @(negedge CLOCK);
    PROT_MODE = pm;
    pcdec_feeder_i.fifo.push_back(b0);
    if (n > 1) pcdec_feeder_i.fifo.push_back(b1);
    if (n > 2) pcdec_feeder_i.fifo.push_back(b2);
    w = 0;
    while (DECODED.valid !== 1'b1 && INVALID_OPCODE !== 1'b1 && FOREIGN.valid !== 1'b1 && w < 64) begin
      @(negedge CLOCK);
      w++;
    end
    chk(w < 64, "no result");
    if (e.kind == 2'h0) begin
      chk(DECODED.valid === 1'b1 && DECODED.op === e.op, "wrong operation");
      chk(INVALID_OPCODE === 1'b0 && FOREIGN.valid === 1'b0, "stray result");
      chk(DECODED.clk_min === e.cmin && DECODED.clk_max === e.cmax, "wrong count");
      if (e.op == PCDEC_OP_SEG_OVERRIDE)
        chk(DECODED.seg_valid === 1'b1 && DECODED.seg_reg === b0[4:3], "wrong segment");
      else
        chk(DECODED.modrm === m && DECODED.modrm_reg === m[5:3] && DECODED.seg_valid === seg_pend
            && (!seg_pend || DECODED.seg_reg === seg_r), "wrong operand");
      if (e.op == PCDEC_OP_COPROC_ESCAPE)
        chk(COPROC_ESCAPE.valid === 1'b1 && COPROC_ESCAPE.escape_high_opcode_bits === b0[2:0]
            && COPROC_ESCAPE.escape_low_opcode_bits === m[5:3] && COPROC_ESCAPE.modrm === m,
            "wrong escape");
    end else if (e.kind == 2'h1)
      chk(INVALID_OPCODE === 1'b1 && DECODED.valid === 1'b0, "invalid not flagged");
    else
      chk(FOREIGN.valid === 1'b1 && FOREIGN.first === b0 && FOREIGN.two_byte === (b0 == 8'h0f)
          && (n < 2 || FOREIGN.second === b1), "foreign not reported");
    seg_pend = (e.kind == 2'h0 && e.op == PCDEC_OP_SEG_OVERRIDE);
    seg_r = b0[4:3];
  endtask

  initial begin
    void'($urandom(32));
    repeat (5) @(posedge CLOCK);
    @(negedge CLOCK);
    RST_B = 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int r = 0; r < 8; r++) begin
        run(8'h0f, 8'h00, {2'h0, r[2:0], 3'h5}, 3, p[0]);
        run(8'h0f, 8'h01, {2'h3, r[2:0], 3'h1}, 3, p[0]);
      end
      run(8'h0f, 8'h02, 8'hd3, 3, p[0]);
      run(8'h0f, 8'h03, 8'h4a, 3, p[0]);
      run(8'h63, 8'hc1, 8'h00, 2, p[0]);
    end
    for (int t = 0; t < 8; t++) run({5'h1b, t[2:0]}, 8'($urandom), 8'h00, 2, 1'b0);
    for (int s = 0; s < 4; s++) begin
      run({3'h1, s[1:0], 3'h6}, 8'h00, 8'h00, 1, 1'b1);
      run(8'h0f, 8'h01, 8'h10, 3, 1'b1);
    end
    run(8'h2e, 8'h00, 8'h00, 1, 1'b1);
    run(8'h0f, 8'h00, 8'h30, 3, 1'b1);
    run(8'h0f, 8'h01, 8'h10, 3, 1'b1);
    run(8'h0f, 8'h06, 8'h00, 2, 1'b1);
    run(8'h90, 8'h00, 8'h00, 1, 1'b0);
    // Reset in mid-instruction must drop the half-taken bytes
    @(negedge CLOCK);
    pcdec_feeder_i.fifo.push_back(8'h0f);
    pcdec_feeder_i.fifo.push_back(8'h01);
    repeat (3) @(negedge CLOCK);
    RST_B = 1'b0;
    @(negedge CLOCK);
    RST_B = 1'b1;
    run(8'h63, 8'h29, 8'h00, 2, 1'b0);
    gap_en = 1'b1;
    repeat (150) begin
      rk = $urandom_range(5);
      rm = 8'($urandom);
      rb = 8'($urandom_range(4));
      case (rk)
        0, 1, 2: run(8'h0f, rb, rm, (rb > 8'h03) ? 2 : 3, rm[0]);
        3: run(8'h63, rm, 8'h00, 2, rm[1]);
        4: run({5'h1b, rm[2:0]}, rm, 8'h00, 2, rm[1]);
        default: run({3'h1, rm[7:6], 3'h6}, 8'h00, 8'h00, 1, rm[1]);
      endcase
    end
    final_report;
  end

  // About 1000 cycles are expected; thirty times that means a hang
  initial begin
    #(8 * 30000);
    err_total++;
    final_report;
  end
endmodule // tb
